// [design/asp_uart.sv]
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module asp_uart (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic xosc_clk_in,
  input wire logic ext_count_input,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic irq_en_out,
  output logic irq_req
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic ack_q;
  wire acc = psel && penable;
  wire done = acc && pready;
  wire wr = done && pwrite;
  wire rd = acc && !pwrite && !ack_q;
  wire hit_ctrl = paddr == asp_pkg::ADDR_CTRL;
  wire hit_data = paddr == asp_pkg::ADDR_DATA;
  wire hit_baud = paddr == asp_pkg::ADDR_BAUD;
  wire hit_tmr = paddr == asp_pkg::ADDR_TMR;
  wire hit_any = hit_ctrl || hit_data || hit_baud || hit_tmr;
  wire wr_ctrl = wr && hit_ctrl;
  wire wr_data = wr && hit_data;
  wire wr_baud = wr && hit_baud;
  // one wait state: read data is registered on the same edge that raises pready
  always_ff @(posedge mclk) begin
    if (rst) ack_q <= 1'b0;
    else ack_q <= acc && !ack_q;
  end
  assign pready = ack_q;
  assign pslverr = done && !hit_any;

  // bus checks
  bus_wait_a: assert property (@(posedge mclk) disable iff (rst)
    acc && !ack_q |=> ack_q)
    else $error("bus wait state not ended");

  ready_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    ack_q |=> !ack_q)
    else $error("ready held longer than one cycle");

  bad_addr_a: assert property (@(posedge mclk) disable iff (rst)
    pslverr |-> !hit_any)
    else $error("error flagged on a mapped address");

  logic [7:0] ctrl_q;
  logic [7:0] rbuf_q;
  logic [7:0] reload_q;
  logic run_q;
  logic ie_q;
  logic [2:0] src_q;
  logic [7:0] ttmr_q;
  logic [7:0] rtmr_q;
  logic [31:0] prdata_d;

  // ----------------------------------------
  // timer clock source
  // ----------------------------------------
  logic [5:0] pre_q;
  logic [2:0] xcnt_q;
  logic x_s1_q, x_s2_q, x_s3_q;
  logic e_s1_q, e_s2_q, e_s3_q;
  wire x_rise = x_s2_q && !x_s3_q;
  wire x_tick = x_rise && xcnt_q == asp_pkg::XOSC_N;
  wire e_tick = !e_s2_q && e_s3_q;

  function automatic logic pre_hit(input logic [5:0] cnt, input logic [5:0] n);
    pre_hit = cnt % n == n - 6'h01;
  endfunction

  logic tick;
  always_comb begin
    unique case (src_q)
      asp_pkg::SRC_SYS: tick = 1'b1;
      asp_pkg::SRC_DIV4: tick = pre_hit(pre_q, asp_pkg::DIV4_N);
      asp_pkg::SRC_DIV12: tick = pre_hit(pre_q, asp_pkg::DIV12_N);
      asp_pkg::SRC_DIV48: tick = pre_hit(pre_q, asp_pkg::DIV48_N);
      asp_pkg::SRC_XOSC8: tick = x_tick;
      asp_pkg::SRC_EXT: tick = e_tick;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pre_q <= 6'h00;
      xcnt_q <= 3'h0;
      {x_s1_q, x_s2_q, x_s3_q} <= 3'h0;
      {e_s1_q, e_s2_q, e_s3_q} <= 3'h0;
    end else begin
      pre_q <= pre_q == asp_pkg::DIV48_N - 6'h01 ? 6'h00 : pre_q + 6'h01;
      xcnt_q <= x_rise ? xcnt_q + 3'h1 : xcnt_q;
      {x_s1_q, x_s2_q, x_s3_q} <= {xosc_clk_in, x_s1_q, x_s2_q};
      {e_s1_q, e_s2_q, e_s3_q} <= {ext_count_input, e_s1_q, e_s2_q};
    end
  end

  // ----------------------------------------
  // baud timers
  // ----------------------------------------
  logic rx_rst_tmr;
  wire t_step = run_q && tick;
  wire t_ovf = t_step && ttmr_q == 8'hff;
  wire r_ovf = t_step && rtmr_q == 8'hff && !rx_rst_tmr;
  logic tdiv_q, rdiv_q;
  wire tx_bit = t_ovf && tdiv_q;
  wire rx_half = r_ovf;
  wire rx_bit = r_ovf && rdiv_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ttmr_q <= asp_pkg::RELOAD_RESET;
      rtmr_q <= asp_pkg::RELOAD_RESET;
      tdiv_q <= 1'b0;
      rdiv_q <= 1'b0;
    end else begin
      if (t_step) ttmr_q <= t_ovf ? reload_q : ttmr_q + 8'h01;
      if (rx_rst_tmr) begin
        rtmr_q <= reload_q;
        rdiv_q <= 1'b0;
      end else if (t_step) begin
        rtmr_q <= r_ovf ? reload_q : rtmr_q + 8'h01;
        if (r_ovf) rdiv_q <= !rdiv_q;
      end
      if (t_ovf) tdiv_q <= !tdiv_q;
    end
  end

  // ----------------------------------------
  // transmitter
  // ----------------------------------------
  asp_pkg::asp_state_t tx_st_q;
  logic [8:0] tsh_q;
  logic [3:0] tcnt_q;
  logic tx_pend_q;
  wire fmt9 = ctrl_q[asp_pkg::CTRL_FMT];
  wire [3:0] nbits = fmt9 ? asp_pkg::BITS_9 : asp_pkg::BITS_8;
  wire tx_ti_set = tx_bit && tx_st_q == asp_pkg::ST_DATA && tcnt_q == nbits - 4'h1;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_st_q <= asp_pkg::ST_IDLE;
      tsh_q <= 9'h000;
      tcnt_q <= 4'h0;
      tx_pend_q <= 1'b0;
      serial_out_pin <= 1'b1;
    end else begin
      if (wr_data) begin
        tsh_q <= {ctrl_q[asp_pkg::CTRL_TB8], pwdata[7:0]};
        tx_pend_q <= 1'b1;
      end
      if (tx_bit) begin
        unique case (tx_st_q)
          asp_pkg::ST_IDLE: begin
            serial_out_pin <= 1'b1;
            if (tx_pend_q && !wr_data) begin
              tx_pend_q <= 1'b0;
              tx_st_q <= asp_pkg::ST_START;
              serial_out_pin <= 1'b0;
            end
          end
          asp_pkg::ST_START: begin
            serial_out_pin <= tsh_q[0];
            tcnt_q <= 4'h1;
            tx_st_q <= asp_pkg::ST_DATA;
          end
          asp_pkg::ST_DATA: begin
            if (tcnt_q == nbits - 4'h1) begin
              serial_out_pin <= 1'b1;
              tx_st_q <= asp_pkg::ST_STOP;
            end else begin
              serial_out_pin <= tsh_q[tcnt_q];
              tcnt_q <= tcnt_q + 4'h1;
            end
          end
          asp_pkg::ST_STOP: tx_st_q <= asp_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // transmit checks
  start_low_a: assert property (@(posedge mclk) disable iff (rst)
    tx_st_q == asp_pkg::ST_START |-> !serial_out_pin)
    else $error("start bit not driven low");

  stop_high_a: assert property (@(posedge mclk) disable iff (rst)
    tx_st_q == asp_pkg::ST_STOP |-> serial_out_pin)
    else $error("stop bit not driven high");

  tx_done_a: assert property (@(posedge mclk) disable iff (rst)
    tx_ti_set |=> ctrl_q[asp_pkg::CTRL_TI])
    else $error("tx done not set at stop bit");

  timer_reload_a: assert property (@(posedge mclk) disable iff (rst)
    t_ovf |=> ttmr_q == $past(reload_q))
    else $error("tx timer did not reload");

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  asp_pkg::asp_state_t rx_st_q;
  logic [8:0] rsh_q;
  logic [3:0] rcnt_q;
  logic rin_q;
  wire start_edge = rin_q && !serial_in_pin;
  wire ren = ctrl_q[asp_pkg::CTRL_REN];
  assign rx_rst_tmr = rx_st_q == asp_pkg::ST_IDLE && ren && start_edge;
  wire rx_last = rx_half && !rdiv_q && rx_st_q == asp_pkg::ST_STOP;
  wire ninth = fmt9 ? rsh_q[8] : serial_in_pin;
  wire filt_ok = !ctrl_q[asp_pkg::CTRL_MCE] || ninth;
  wire rx_accept = rx_last && !ctrl_q[asp_pkg::CTRL_RI] && filt_ok;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_st_q <= asp_pkg::ST_IDLE;
      rsh_q <= 9'h000;
      rcnt_q <= 4'h0;
      rin_q <= 1'b1;
      rbuf_q <= 8'h00;
    end else begin
      rin_q <= serial_in_pin;
      if (rx_rst_tmr) rx_st_q <= asp_pkg::ST_START;
      else if (rx_half && !rdiv_q) begin
        // mid-bit sample; each bit spans two rx overflows
        unique case (rx_st_q)
          asp_pkg::ST_IDLE: ;
          asp_pkg::ST_START: begin
            rcnt_q <= 4'h0;
            rx_st_q <= serial_in_pin ? asp_pkg::ST_IDLE : asp_pkg::ST_DATA;
          end
          asp_pkg::ST_DATA: begin
            rsh_q[rcnt_q] <= serial_in_pin;
            rcnt_q <= rcnt_q + 4'h1;
            if (rcnt_q == nbits - 4'h2) rx_st_q <= asp_pkg::ST_STOP;
          end
          asp_pkg::ST_STOP: rx_st_q <= asp_pkg::ST_IDLE;
        endcase
      end
      if (rx_accept) rbuf_q <= rsh_q[7:0];
    end
  end

  // receive checks
  rx_gate_a: assert property (@(posedge mclk) disable iff (rst)
    rx_st_q == asp_pkg::ST_IDLE && !ren |=> rx_st_q == asp_pkg::ST_IDLE)
    else $error("receiver left idle while disabled");

  start_realign_a: assert property (@(posedge mclk) disable iff (rst)
    rx_rst_tmr |=> rtmr_q == $past(reload_q) && !rdiv_q)
    else $error("rx timer not reloaded on start");

  false_start_a: assert property (@(posedge mclk) disable iff (rst)
    rx_st_q == asp_pkg::ST_START && rx_half && !rdiv_q && serial_in_pin |=> rx_st_q == asp_pkg::ST_IDLE)
    else $error("false start not dropped");

  overrun_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[asp_pkg::CTRL_RI] |=> $stable(rbuf_q))
    else $error("buffer overwritten while rx done set");

  // ----------------------------------------
  // control register and flags
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= asp_pkg::CTRL_RESET;
      reload_q <= asp_pkg::RELOAD_RESET;
      run_q <= 1'b0;
      ie_q <= 1'b0;
      src_q <= asp_pkg::SRC_SYS;
    end else begin
      if (wr_ctrl) ctrl_q <= {pwdata[7], 1'b1, pwdata[5:0]};
      if (wr_baud) begin
        reload_q <= pwdata[7:0];
        run_q <= pwdata[asp_pkg::BAUD_RUN];
        src_q <= pwdata[asp_pkg::BAUD_SEL_LO +: 3];
        ie_q <= pwdata[asp_pkg::BAUD_SEL_LO + 3];
      end
      // set wins over a same-cycle software clear
      if (tx_ti_set) ctrl_q[asp_pkg::CTRL_TI] <= 1'b1;
      if (rx_accept) begin
        ctrl_q[asp_pkg::CTRL_RI] <= 1'b1;
        ctrl_q[asp_pkg::CTRL_RB8] <= ninth;
      end
    end
  end

  assign irq_en_out = ie_q;
  assign irq_req = ie_q && (ctrl_q[asp_pkg::CTRL_TI] || ctrl_q[asp_pkg::CTRL_RI]);

  // flag checks
  rx_sticky_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[asp_pkg::CTRL_RI] && !wr_ctrl |=> ctrl_q[asp_pkg::CTRL_RI])
    else $error("rx done cleared by hardware");

  tx_sticky_a: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[asp_pkg::CTRL_TI] && !wr_ctrl |=> ctrl_q[asp_pkg::CTRL_TI])
    else $error("tx done cleared by hardware");

  rx_set_a: assert property (@(posedge mclk) disable iff (rst)
    rx_accept |=> ctrl_q[asp_pkg::CTRL_RI] && ctrl_q[asp_pkg::CTRL_RB8] == $past(ninth))
    else $error("accepted frame not flagged");

  irq_gate_a: assert property (@(posedge mclk) disable iff (rst)
    irq_req |-> ie_q)
    else $error("interrupt request while disabled");

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_ctrl) prdata_d = {24'h0, ctrl_q};
    if (hit_data) prdata_d = {24'h0, rbuf_q};
    if (hit_baud) prdata_d = {19'h0, ie_q, src_q, run_q, reload_q};
    if (hit_tmr) prdata_d = {24'h0, ttmr_q};
  end
  always_ff @(posedge mclk) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (rd) prdata <= prdata_d;
  end

  // ----------------------------------------
  // scenario coverage
  // ----------------------------------------
  tx_frame_c: cover property (@(posedge mclk) disable iff (rst)
    tx_ti_set);

  rx_nine_c: cover property (@(posedge mclk) disable iff (rst)
    rx_accept && fmt9);

  filtered_c: cover property (@(posedge mclk) disable iff (rst)
    rx_last && !filt_ok);

  overrun_c: cover property (@(posedge mclk) disable iff (rst)
    rx_last && ctrl_q[asp_pkg::CTRL_RI]);
endmodule

// [design/asp_pkg.sv]
package asp_pkg;
  // ----------------------------------------
  // register map (byte addresses on apb)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_TMR = 8'h0c;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_FMT = 7;
  localparam int CTRL_MCE = 5;
  localparam int CTRL_REN = 4;
  localparam int CTRL_TB8 = 3;
  localparam int CTRL_RB8 = 2;
  localparam int CTRL_TI = 1;
  localparam int CTRL_RI = 0;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  // ----------------------------------------
  // baud/timer register fields
  // ----------------------------------------
  localparam int BAUD_RUN = 8;
  localparam int BAUD_SEL_LO = 9;
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_DIV4 = 3'h1;
  localparam logic [2:0] SRC_DIV12 = 3'h2;
  localparam logic [2:0] SRC_DIV48 = 3'h3;
  localparam logic [2:0] SRC_XOSC8 = 3'h4;
  localparam logic [2:0] SRC_EXT = 3'h5;
  localparam logic [5:0] DIV4_N = 6'h04;
  localparam logic [5:0] DIV12_N = 6'h0c;
  localparam logic [5:0] DIV48_N = 6'h30;
  localparam logic [2:0] XOSC_N = 3'h7;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [3:0] BITS_8 = 4'h9;
  localparam logic [3:0] BITS_9 = 4'ha;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} asp_state_t;
endpackage

// [tb/asp_remote.sv]
`timescale 1ns/100ps
// ----------------------------------------
// far-end serial device
// ----------------------------------------
module asp_remote #(
  parameter int BIT = 8
) (
  input wire logic mclk,
  input wire logic line_in,
  output logic line_out,
  output logic [9:0] rx_bits,
  output int rx_cnt
);
  initial begin
    line_out = 1'b1;
  end
  // d[8] is the ninth bit, or the stop level in 8-bit frames
  task automatic send(input logic [8:0] d);
    logic [10:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge mclk);
    end
  endtask
  // mid-bit sampling after the falling start edge
  always begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      repeat (BIT) @(posedge mclk);
      rx_bits[i] = line_in;
    end
    rx_cnt++;
  end
endmodule

// [tb/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] RLD = 8'hfc;
  localparam int BIT = 2 * (256 - int'(RLD));
  typedef struct {logic f; logic n; logic [7:0] d;} asp_row_t;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, xosc, ext, sin, sout, irq_en, irq, perr;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, rv;
  logic [9:0] rb;
  int rc, k, miscompares, checks, cyc;
  asp_row_t r;
  asp_row_t rows[4] = '{'{1'b0, 1'b1, 8'ha5}, '{1'b0, 1'b0, 8'h3c}, '{1'b1, 1'b1, 8'h01}, '{1'b1, 1'b0, 8'hfe}};
  asp_uart asp_uart_inst (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xosc_clk_in(xosc), .ext_count_input(ext), .serial_in_pin(sin), .serial_out_pin(sout),
    .irq_en_out(irq_en), .irq_req(irq));
  asp_remote #(.BIT(BIT)) asp_remote_inst (.mclk(mclk), .line_in(sout), .line_out(sin),
    .rx_bits(rb), .rx_cnt(rc));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    perr = pslverr;
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task wt(input int n0);
    k = 0;
    while (rc == n0 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    chk(rc != n0, 1);
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    rst <= 1'b1;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    xosc <= 1'b0;
    ext <= 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(sout, 1);
    chk(irq, 0);
    rdc(asp_pkg::ADDR_CTRL, asp_pkg::CTRL_RESET);
    xfer(1'b1, asp_pkg::ADDR_BAUD, {19'h0, 1'b1, asp_pkg::SRC_SYS, 1'b1, RLD});
    chk(irq_en, 1);
    for (int i = 0; i < 4; i++) begin
      r = rows[i];
      c = {r.f, 7'h50} | {4'h0, r.n, 3'h0};
      xfer(1'b1, asp_pkg::ADDR_CTRL, {24'h0, c});
      k = rc;
      xfer(1'b1, asp_pkg::ADDR_DATA, {24'h0, r.d});
      wt(k);
      chk(rb[7:0], r.d);
      chk(rb[8], r.f ? r.n : 1'b1);
      chk(rb[9], 1);
      rdc(asp_pkg::ADDR_CTRL, c | 8'h02);
      chk(irq, 1);
      xfer(1'b1, asp_pkg::ADDR_CTRL, {24'h0, c});
      chk(irq, 0);
      asp_remote_inst.send({r.n, r.d});
      rdc(asp_pkg::ADDR_CTRL, c | 8'h01 | {5'h0, r.n, 2'h0});
      rdc(asp_pkg::ADDR_DATA, r.d);
      xfer(1'b1, asp_pkg::ADDR_CTRL, {24'h0, c});
    end
    // overrun keeps first byte
    xfer(1'b1, asp_pkg::ADDR_CTRL, 32'h50);
    asp_remote_inst.send(9'h155);
    asp_remote_inst.send(9'h1aa);
    rdc(asp_pkg::ADDR_CTRL, 32'h55);
    rdc(asp_pkg::ADDR_DATA, 32'h55);
    // address filtering
    xfer(1'b1, asp_pkg::ADDR_CTRL, 32'hf0);
    asp_remote_inst.send(9'h011);
    rdc(asp_pkg::ADDR_CTRL, 32'hf0);
    asp_remote_inst.send(9'h122);
    rdc(asp_pkg::ADDR_CTRL, 32'hf5);
    rdc(asp_pkg::ADDR_DATA, 32'h22);
    xfer(1'b1, asp_pkg::ADDR_CTRL, 32'hd0);
    asp_remote_inst.send(9'h033);
    rdc(asp_pkg::ADDR_CTRL, 32'hd1);
    rdc(asp_pkg::ADDR_DATA, 32'h33);
    xfer(1'b1, asp_pkg::ADDR_CTRL, 32'h70);
    asp_remote_inst.send(9'h044);
    rdc(asp_pkg::ADDR_CTRL, 32'h70);
    // receiver disabled, then a write to an unmapped address
    xfer(1'b1, asp_pkg::ADDR_CTRL, 32'h40);
    asp_remote_inst.send(9'h177);
    rdc(asp_pkg::ADDR_CTRL, 32'h40);
    rdc(asp_pkg::ADDR_DATA, 32'h33);
    xfer(1'b1, 8'h10, 32'h0);
    chk(perr, 1);
    // start bit length on the wire
    xfer(1'b1, asp_pkg::ADDR_DATA, 32'hff);
    while (sout !== 1'b0) @(negedge mclk);
    k = 0;
    while (sout === 1'b0) begin
      @(negedge mclk);
      k++;
    end
    chk(k, BIT);
    // reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk(sout, 1);
    chk(irq, 0);
    rdc(asp_pkg::ADDR_CTRL, asp_pkg::CTRL_RESET);
    // timer clock from external count, then from oscillator
    xfer(1'b1, asp_pkg::ADDR_BAUD, {19'h0, 1'b0, asp_pkg::SRC_EXT, 1'b1, RLD});
    repeat (3) begin
      ext <= 1'b1;
      repeat (3) @(posedge mclk);
      ext <= 1'b0;
      repeat (3) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    rdc(asp_pkg::ADDR_TMR, 32'h3);
    xfer(1'b1, asp_pkg::ADDR_BAUD, {19'h0, 1'b0, asp_pkg::SRC_XOSC8, 1'b1, RLD});
    repeat (16) begin
      xosc <= 1'b1;
      repeat (2) @(posedge mclk);
      xosc <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    rdc(asp_pkg::ADDR_TMR, 32'h5);
    print_verdict();
  end
endmodule
